// ===== design/rta_alarm_match.sv
// Per-field alarm comparator with individual and global enables
`timescale 1ns/1ps
`default_nettype none
module rta_alarm_match (
  input wire logic [31:0] alarm_date,
  input wire logic [31:0] alarm_time,
  input wire logic [31:0] cur_date,
  input wire logic [31:0] cur_time,
  input wire logic global_alarm_on,
  output logic alarm_hit
);

  logic [rta_pkg::NUM_FIELDS-1:0] field_ok;

  // A disabled field always passes, so fewer enables give a recurring alarm
  for (genvar i = 0; i < rta_pkg::NUM_FIELDS; i++) begin : g_field
    localparam logic [31:0] MASK =
      32'((64'h1 << rta_pkg::FLD_W[i]) - 64'h1);
    logic [31:0] a_src;
    logic [31:0] c_src;
    logic on;
    assign a_src = rta_pkg::FLD_IS_DATE[i] ? alarm_date : alarm_time;
    assign c_src = rta_pkg::FLD_IS_DATE[i] ? cur_date : cur_time;
    assign on = a_src[rta_pkg::FLD_ON[i]];
    assign field_ok[i] = !on || ((((a_src ^ c_src) >> rta_pkg::FLD_LSB[i])
                         & MASK) == 32'h0);
  end

  // Whole match only while the global enable is set
  assign alarm_hit = global_alarm_on && (&field_ok);

endmodule : rta_alarm_match
`default_nettype wire

// ===== design/rta_alarm_top.sv
// Calendar clock alarm-match and interrupt block with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module rta_alarm_top #(
  parameter int unsigned TICK_CYCLES = rta_pkg::TICK_CYCLES,
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] waddr, next_waddr, raddr_byte;
  logic [31:0] wdata, next_wdata;
  logic [3:0] wstrb, next_wstrb;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata, rd_mux;
  logic do_write, do_read;
  logic ctrl_enable, next_ctrl_enable;
  logic [31:0] alarm_date_setup, next_alarm_date_setup;
  logic [31:0] alarm_time_setup, next_alarm_time_setup;
  logic irq_raw_flag, next_irq_raw_flag;
  logic irq_enable_mask, next_irq_enable_mask;
  logic irq_force_bit, next_irq_force_bit;
  logic irq_masked_status;
  logic match_active, next_match_active;
  logic hit_prev, next_hit_prev;
  logic [31:0] date_shadow, next_date_shadow;
  logic [31:0] cur_date, cur_time;
  logic alarm_hit, running, global_alarm_on;
  logic [11:0] year;
  logic [3:0] month;
  logic [4:0] day, hour;
  logic [2:0] wday;
  logic [5:0] minute, second;

  // Known offset check, used by both read and write paths
  function automatic logic reg_known(input logic [7:0] a);
    case (a)
      rta_pkg::OFF_CTRL, rta_pkg::OFF_ALARM_DATE, rta_pkg::OFF_ALARM_TIME,
      rta_pkg::OFF_CUR_DATE, rta_pkg::OFF_CUR_TIME, rta_pkg::OFF_IRQ_RAW,
      rta_pkg::OFF_IRQ_ENABLE, rta_pkg::OFF_IRQ_FORCE,
      rta_pkg::OFF_IRQ_STATUS: reg_known = 1'b1;
      default: reg_known = 1'b0;
    endcase
  endfunction : reg_known

  // Byte-lane merge limited to writable bits
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb,
                                        input logic [31:0] wmask);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = ((old_v & ~lanes) | (new_v & lanes)) & wmask;
  endfunction : merge

  // ----------------------------------------------------------------
  // Counter core and comparator
  // ----------------------------------------------------------------
  rta_time_core #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_core (
    .clk(clk),
    .reset(reset),
    .run_enable(ctrl_enable),
    .running(running),
    .year(year),
    .month(month),
    .day(day),
    .wday(wday),
    .hour(hour),
    .minute(minute),
    .second(second)
  );

  // Running values laid out as the alarm registers
  assign cur_date = {8'h0, year, month, 3'h0, day};
  assign cur_time = {5'h0, wday, 3'h0, hour, 2'h0, minute, 2'h0, second};
  assign global_alarm_on = alarm_date_setup[rta_pkg::GLOBAL_ON_BIT];

  rta_alarm_match u_match (
    .alarm_date(alarm_date_setup),
    .alarm_time(alarm_time_setup),
    .cur_date(cur_date),
    .cur_time(cur_time),
    .global_alarm_on(global_alarm_on),
    .alarm_hit(alarm_hit)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------
  // Address and data are parked separately; the write fires once both sit
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign raddr_byte = 8'(s_axi_araddr);

  // Read data selection; reserved bits read zero
  always_comb begin
    rd_mux = 32'h0;
    case (raddr_byte)
      rta_pkg::OFF_CTRL: begin
        rd_mux[rta_pkg::CTRL_ENABLE_BIT] = ctrl_enable;
        rd_mux[rta_pkg::CTRL_ACTIVE_BIT] = running;
      end
      rta_pkg::OFF_ALARM_DATE: begin
        rd_mux = alarm_date_setup;
        rd_mux[rta_pkg::MATCH_ACTIVE_BIT] = match_active;
      end
      rta_pkg::OFF_ALARM_TIME: rd_mux = alarm_time_setup;
      rta_pkg::OFF_CUR_DATE: rd_mux = date_shadow;
      rta_pkg::OFF_CUR_TIME: rd_mux = cur_time;
      rta_pkg::OFF_IRQ_RAW: rd_mux[rta_pkg::IRQ_BIT] = irq_raw_flag;
      rta_pkg::OFF_IRQ_ENABLE: rd_mux[rta_pkg::IRQ_BIT] = irq_enable_mask;
      rta_pkg::OFF_IRQ_FORCE: rd_mux[rta_pkg::IRQ_BIT] = irq_force_bit;
      rta_pkg::OFF_IRQ_STATUS: rd_mux[rta_pkg::IRQ_BIT] = irq_masked_status;
      default: rd_mux = 32'h0;
    endcase
  end

  // Bus channel next state
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_waddr = waddr;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_waddr = 8'(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_wdata = s_axi_wdata;
      next_wstrb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = reg_known(waddr) ? rta_pkg::RESP_OKAY : rta_pkg::RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rdata = rd_mux;
      next_rresp = reg_known(raddr_byte) ? rta_pkg::RESP_OKAY
                                         : rta_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Bus channel registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      waddr <= 8'h0;
      wdata <= 32'h0;
      wstrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      waddr <= next_waddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Control, alarm and interrupt registers
  // ----------------------------------------------------------------
  // Software must leave the fields alone while the global enable is on;
  // the hardware does not lock them, it only compares what it holds
  always_comb begin
    next_ctrl_enable = ctrl_enable;
    next_alarm_date_setup = alarm_date_setup;
    next_alarm_time_setup = alarm_time_setup;
    next_irq_enable_mask = irq_enable_mask;
    next_irq_force_bit = irq_force_bit;
    next_irq_raw_flag = irq_raw_flag;
    next_match_active = global_alarm_on;
    next_hit_prev = alarm_hit;
    next_date_shadow = date_shadow;
    if (do_read && raddr_byte == rta_pkg::OFF_CUR_TIME) begin
      next_date_shadow = cur_date;
    end
    if (do_write && wstrb[0]) begin
      case (waddr)
        rta_pkg::OFF_CTRL:
          next_ctrl_enable = wdata[rta_pkg::CTRL_ENABLE_BIT];
        rta_pkg::OFF_IRQ_RAW:
          if (wdata[rta_pkg::IRQ_BIT]) next_irq_raw_flag = 1'b0;
        rta_pkg::OFF_IRQ_ENABLE:
          next_irq_enable_mask = wdata[rta_pkg::IRQ_BIT];
        rta_pkg::OFF_IRQ_FORCE:
          next_irq_force_bit = wdata[rta_pkg::IRQ_BIT];
        default: ;
      endcase
    end
    if (do_write && waddr == rta_pkg::OFF_ALARM_DATE) begin
      next_alarm_date_setup = merge(alarm_date_setup, wdata, wstrb,
                                    rta_pkg::ALARM_DATE_WMASK);
    end
    if (do_write && waddr == rta_pkg::OFF_ALARM_TIME) begin
      next_alarm_time_setup = merge(alarm_time_setup, wdata, wstrb,
                                    rta_pkg::ALARM_TIME_WMASK);
    end
    // Rising edge only, so a held match cannot block a clear; set wins
    if (alarm_hit && !hit_prev) begin
      next_irq_raw_flag = 1'b1;
    end
  end

  // Register state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_enable <= 1'b0;
      alarm_date_setup <= rta_pkg::RST_ALARM_DATE;
      alarm_time_setup <= rta_pkg::RST_ALARM_TIME;
      irq_enable_mask <= 1'b0;
      irq_force_bit <= 1'b0;
      irq_raw_flag <= 1'b0;
      match_active <= 1'b0;
      hit_prev <= 1'b0;
      date_shadow <= 32'h0;
    end else begin
      ctrl_enable <= next_ctrl_enable;
      alarm_date_setup <= next_alarm_date_setup;
      alarm_time_setup <= next_alarm_time_setup;
      irq_enable_mask <= next_irq_enable_mask;
      irq_force_bit <= next_irq_force_bit;
      irq_raw_flag <= next_irq_raw_flag;
      match_active <= next_match_active;
      hit_prev <= next_hit_prev;
      date_shadow <= next_date_shadow;
    end
  end

  // Masked and forced status drives the interrupt line
  assign irq_masked_status = (irq_raw_flag & irq_enable_mask) | irq_force_bit;
  assign irq = irq_masked_status;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_raw_on_match: assert property (@(posedge clk) disable iff (reset)
    (alarm_hit && !hit_prev) |=> irq_raw_flag)
    else $error("raw flag missed an alarm match");

  a_global_gate: assert property (@(posedge clk) disable iff (reset)
    !global_alarm_on |-> !alarm_hit ##1 !match_active)
    else $error("match seen with global enable off");

  a_irq_combine: assert property (@(posedge clk) disable iff (reset)
    irq_force_bit || (irq_raw_flag && irq_enable_mask) |-> irq)
    else $error("interrupt low with cause present");

  a_date_fields: assert property (@(posedge clk) disable iff (reset)
    (alarm_date_setup & ~rta_pkg::ALARM_DATE_WMASK) == 32'h0)
    else $error("reserved date alarm bit set");

  a_time_fields: assert property (@(posedge clk) disable iff (reset)
    (alarm_time_setup & ~rta_pkg::ALARM_TIME_WMASK) == 32'h0)
    else $error("reserved time alarm bit set");

  a_seconds_only: assert property (@(posedge clk) disable iff (reset)
    (global_alarm_on && alarm_time_setup[31:28] == 4'h1
     && alarm_date_setup[26:24] == 3'h0
     && alarm_time_setup[5:0] == second) |-> alarm_hit)
    else $error("seconds-only alarm did not match");

  a_date_snapshot: assert property (@(posedge clk) disable iff (reset)
    (do_read && raddr_byte == rta_pkg::OFF_CUR_TIME)
    |=> date_shadow == $past(cur_date))
    else $error("date snapshot not taken with time read");

  a_time_alarm_reset: assert property (@(posedge clk)
    $fell(reset) |-> alarm_time_setup == 32'h0)
    else $error("time alarm not zero after reset");

endmodule : rta_alarm_top
`default_nettype wire

// ===== design/rta_pkg.sv
// Package of offsets, field layouts, reset values and timing for the alarm block
package rta_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h0c;
  localparam logic [7:0] OFF_ALARM_DATE = 8'h10;
  localparam logic [7:0] OFF_ALARM_TIME = 8'h14;
  localparam logic [7:0] OFF_CUR_DATE = 8'h18;
  localparam logic [7:0] OFF_CUR_TIME = 8'h1c;
  localparam logic [7:0] OFF_IRQ_RAW = 8'h20;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h24;
  localparam logic [7:0] OFF_IRQ_FORCE = 8'h28;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h2c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int YEAR_LSB = 12;
  localparam int MONTH_LSB = 8;
  localparam int DAY_LSB = 0;
  localparam int WDAY_LSB = 24;
  localparam int HOUR_LSB = 16;
  localparam int MIN_LSB = 8;
  localparam int SEC_LSB = 0;
  localparam int YEAR_ON_BIT = 26;
  localparam int MONTH_ON_BIT = 25;
  localparam int DAY_ON_BIT = 24;
  localparam int GLOBAL_ON_BIT = 28;
  localparam int MATCH_ACTIVE_BIT = 29;
  localparam int WDAY_ON_BIT = 31;
  localparam int HOUR_ON_BIT = 30;
  localparam int MIN_ON_BIT = 29;
  localparam int SEC_ON_BIT = 28;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_ACTIVE_BIT = 1;
  localparam int IRQ_BIT = 0;

  // Compare table: year, month, day, weekday, hour, minute, second
  localparam int NUM_FIELDS = 7;
  localparam int FLD_LSB [NUM_FIELDS] = '{YEAR_LSB, MONTH_LSB, DAY_LSB,
    WDAY_LSB, HOUR_LSB, MIN_LSB, SEC_LSB};
  localparam int FLD_W [NUM_FIELDS] = '{12, 4, 5, 3, 5, 6, 6};
  localparam int FLD_ON [NUM_FIELDS] = '{YEAR_ON_BIT, MONTH_ON_BIT,
    DAY_ON_BIT, WDAY_ON_BIT, HOUR_ON_BIT, MIN_ON_BIT, SEC_ON_BIT};
  localparam bit FLD_IS_DATE [NUM_FIELDS] = '{1, 1, 1, 0, 0, 0, 0};

  // Writable bits; everything else is reserved and reads zero, except date alarm bit 29, which reads match_active
  localparam logic [31:0] ALARM_DATE_WMASK = 32'h17ffff1f;
  localparam logic [31:0] ALARM_TIME_WMASK = 32'hf71f3f3f;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_ALARM_DATE = 32'h00000000;
  localparam logic [31:0] RST_ALARM_TIME = 32'h00000000;
  localparam logic [11:0] RST_YEAR = 12'h000;
  localparam logic [3:0] RST_MONTH = 4'h1;
  localparam logic [4:0] RST_DAY = 5'h01;
  localparam logic [2:0] RST_WDAY = 3'h0;

  // Calendar limits
  localparam logic [3:0] MONTH_MAX = 4'hc;
  localparam logic [2:0] WDAY_MAX = 3'h6;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [5:0] MIN_MAX = 6'h3b;
  localparam logic [5:0] SEC_MAX = 6'h3b;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 200000000;
  localparam longint TICK_PERIOD_S = 1;
  localparam int unsigned TICK_CYCLES = int'(CLK_HZ * TICK_PERIOD_S);

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : rta_pkg

// ===== design/rta_time_core.sv
// Running calendar counter, advanced once per second while enabled
`timescale 1ns/1ps
`default_nettype none
module rta_time_core #(
  parameter int unsigned TICK_CYCLES = rta_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic run_enable,
  output logic running,
  output logic [11:0] year,
  output logic [3:0] month,
  output logic [4:0] day,
  output logic [2:0] wday,
  output logic [4:0] hour,
  output logic [5:0] minute,
  output logic [5:0] second
);

  logic [31:0] div, next_div;
  logic next_running;
  logic [11:0] next_year;
  logic [3:0] next_month;
  logic [4:0] next_day;
  logic [2:0] next_wday;
  logic [4:0] next_hour;
  logic [5:0] next_minute;
  logic [5:0] next_second;
  logic tick;

  // Leap years taken as every fourth year; century rule is software's job
  function automatic logic [4:0] month_len(input logic [3:0] m,
                                           input logic [11:0] y);
    case (m)
      4'h2: month_len = (y[1:0] == 2'h0) ? 5'd29 : 5'd28;
      4'h4, 4'h6, 4'h9, 4'hb: month_len = 5'd30;
      default: month_len = 5'd31;
    endcase
  endfunction : month_len

  // Second divider and calendar carry chain
  always_comb begin
    next_running = run_enable;
    next_div = div;
    next_year = year;
    next_month = month;
    next_day = day;
    next_wday = wday;
    next_hour = hour;
    next_minute = minute;
    next_second = second;
    tick = run_enable && (div == 32'(TICK_CYCLES - 1));
    if (!run_enable) begin
      next_div = 32'h0;
    end else if (tick) begin
      next_div = 32'h0;
    end else begin
      next_div = div + 32'h1;
    end
    if (tick) begin
      next_second = second + 6'h1;
      if (second == rta_pkg::SEC_MAX) begin
        next_second = 6'h0;
        next_minute = minute + 6'h1;
        if (minute == rta_pkg::MIN_MAX) begin
          next_minute = 6'h0;
          next_hour = hour + 5'h1;
          if (hour == rta_pkg::HOUR_MAX) begin
            next_hour = 5'h0;
            // Sunday is 0, Monday 1 .. Saturday 6
            next_wday = (wday == rta_pkg::WDAY_MAX) ? 3'h0 : wday + 3'h1;
            next_day = day + 5'h1;
            if (day == month_len(month, year)) begin
              next_day = 5'h1;
              next_month = month + 4'h1;
              if (month == rta_pkg::MONTH_MAX) begin
                next_month = 4'h1;
                next_year = year + 12'h1;
              end
            end
          end
        end
      end
    end
  end

  // Counter state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div <= 32'h0;
      running <= 1'b0;
      year <= rta_pkg::RST_YEAR;
      month <= rta_pkg::RST_MONTH;
      day <= rta_pkg::RST_DAY;
      wday <= rta_pkg::RST_WDAY;
      hour <= 5'h0;
      minute <= 6'h0;
      second <= 6'h0;
    end else begin
      div <= next_div;
      running <= next_running;
      year <= next_year;
      month <= next_month;
      day <= next_day;
      wday <= next_wday;
      hour <= next_hour;
      minute <= next_minute;
      second <= next_second;
    end
  end

  a_month_range: assert property (@(posedge clk) disable iff (reset)
    (month >= 4'h1) && (month <= 4'hc) && (day >= 5'h1))
    else $error("month or day out of range");

  a_weekday_range: assert property (@(posedge clk) disable iff (reset)
    wday <= 3'h6)
    else $error("weekday out of range");

  a_hold_stopped: assert property (@(posedge clk) disable iff (reset)
    !run_enable |=> $stable(second) && $stable(minute) && !running)
    else $error("clock moved while disabled");

endmodule : rta_time_core
`default_nettype wire

// ===== tb/tb_rta_alarm_match_irq.sv
// Register-level testbench for the alarm-match and interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_rta_alarm_match_irq;
  // ----------------------------------------------------------------
  // Signals and design instance
  // ----------------------------------------------------------------
  logic clk = 1'b0, reset = 1'b1, irq;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] rd;
  int n_errors = 0, tests_run = 0, cycles = 0;
  // Short tick keeps one second at four clocks
  rta_alarm_top #(.TICK_CYCLES(4), .ADDR_W(8)) DUT (.clk(clk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Hang guard; the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("errors %0d compares %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Ready is sampled mid-cycle, where it equals its value at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, aw_t, w_t, b_t;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge clk);
      aw_t = s_axi_awready && !aw_ok;
      w_t = s_axi_wready && !w_ok;
      @(posedge clk);
      if (aw_t) begin
        s_axi_awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (w_t) begin
        s_axi_wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    b_t = 1'b0;
    while (!b_t) begin
      @(negedge clk);
      b_t = (s_axi_bvalid === 1'b1);
      rsp = s_axi_bresp;
      @(posedge clk);
    end
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    logic t;
    t = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!t) begin
      @(negedge clk);
      t = s_axi_arready;
      @(posedge clk);
    end
    s_axi_arvalid <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(negedge clk);
      t = (s_axi_rvalid === 1'b1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk);
    end
    s_axi_rready <= 1'b0;
  endtask : rdr
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rdr(a);
    chk(rd, exp);
  endtask : rchk
  task automatic wait_irq(input logic exp, input int max_c);
    int n;
    n = 0;
    while (irq !== exp && n < max_c) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, irq}, {31'h0, exp});
  endtask : wait_irq
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    // Reset values of alarm and interrupt registers
    for (int i = 0; i < 6; i++) rchk(8'h10 + ((i < 2) ? 8'(4 * i) :
      8'(4 * i + 8)), 32'h0);
    // Stopped clock holds the reset calendar, time read first
    rchk(rta_pkg::OFF_CUR_TIME, 32'h0);
    rchk(rta_pkg::OFF_CUR_DATE, 32'h00000101);
    rchk(rta_pkg::OFF_CTRL, 32'h0);
    // Unmapped place answers with an error both ways
    rchk(8'h30, 32'h0);
    chk({30'h0, rsp}, {30'h0, rta_pkg::RESP_SLVERR});
    wr(8'h30, 32'hffffffff);
    chk({30'h0, rsp}, {30'h0, rta_pkg::RESP_SLVERR});
    // Field layout and reserved bits; active follows global enable
    wr(rta_pkg::OFF_ALARM_TIME, 32'hffffffff);
    rchk(rta_pkg::OFF_ALARM_TIME, rta_pkg::ALARM_TIME_WMASK);
    wr(rta_pkg::OFF_ALARM_DATE, 32'hffffffff);
    rchk(rta_pkg::OFF_ALARM_DATE, 32'h37ffff1f);
    wr(rta_pkg::OFF_ALARM_DATE, 32'h0);
    wr(rta_pkg::OFF_ALARM_TIME, 32'h0);
    rchk(rta_pkg::OFF_ALARM_DATE, 32'h0);
    // Force drives the output with raw and enable clear
    wr(rta_pkg::OFF_IRQ_FORCE, 32'h1);
    wait_irq(1'b1, 8);
    rchk(rta_pkg::OFF_IRQ_STATUS, 32'h1);
    wr(rta_pkg::OFF_IRQ_FORCE, 32'h0);
    wait_irq(1'b0, 8);
    // Seconds-only alarm at second three, clock started
    wr(rta_pkg::OFF_ALARM_TIME, 32'h10000003);
    wr(rta_pkg::OFF_ALARM_DATE, 32'h10000000);
    wr(rta_pkg::OFF_IRQ_ENABLE, 32'h1);
    wr(rta_pkg::OFF_CTRL, 32'h1);
    rchk(rta_pkg::OFF_CTRL, 32'h3);
    wait_irq(1'b1, 100);
    rchk(rta_pkg::OFF_IRQ_RAW, 32'h1);
    // Mask hides a pending raw flag
    wr(rta_pkg::OFF_IRQ_ENABLE, 32'h0);
    wait_irq(1'b0, 8);
    rchk(rta_pkg::OFF_IRQ_RAW, 32'h1);
    wr(rta_pkg::OFF_IRQ_ENABLE, 32'h1);
    wr(rta_pkg::OFF_IRQ_RAW, 32'h1);
    wait_irq(1'b0, 8);
    // Minute later the same second matches again
    wait_irq(1'b1, 300);
    // Every field enabled, matching minute two second three
    wr(rta_pkg::OFF_ALARM_DATE, 32'h0);
    wr(rta_pkg::OFF_IRQ_RAW, 32'h1);
    wait_irq(1'b0, 8);
    wr(rta_pkg::OFF_ALARM_TIME, 32'hf0000203);
    wr(rta_pkg::OFF_ALARM_DATE, 32'h17000101);
    wait_irq(1'b1, 300);
    end_sim();
  end
endmodule : tb_rta_alarm_match_irq
`default_nettype wire
